// [inc/sssq_pkg.sv]
// Functional notes
// R1 - backed mode: sense below trip on power-down pulses early-warning interrupt
// R2 - backed mode: supply below trip never asserts reset
// R3 - supply below trip forces memory select inactive high
// R4 - supply at backup cell level asserts both power-fail outputs, any mode
// R5 - non-backed mode: supply below trip drives reset after early warning
// R6 - non-backed mode: early warning floats late in power-down
// R7 - non-backed power-up: clear power-fail above cell, assert reset and warning
// R8 - power-up reset lasts full interval even if warning pulse is cut
// R9 - after power-up, each new sense fall gives a fresh early warning
// R10 - missing strobe before watchdog period expires gives watchdog reset
// R11 - non-backed power-up issues reset immediately
// R12 - backed power-up issues reset when sense rises above trip
// R13 - processor drops wake/sleep control only after the setup gap past strobe
// R14 - sleep disables all comparators; the code masks only the sense result, supply and cell results stay live
// R15 - asleep with power: warning and resets off, strobe and sense ignored
// R16 - pushbutton falling edge ends sleep
// R17 - after pushbutton wake, watchdog expiry restarts processor with reset
// R18 - power loss while asleep: wake when supply rises above cell level
// R19 - non-backed mode: power loss during sleep drives reset
// R20 - backed mode: power loss during sleep keeps reset inactive
// R21 - backed mode: pushbutton wake ignores sense level
// R22 - backed mode: power-up after sleep asserts reset above cell level
// R23 - mode pin low selects non-backed, high selects backed
// R24 - power-down warning pulses low for a bounded minimum, then returns high
// R25 - comparator events arrive synchronized; interval counters are parameters
// R26 - active-high and active-low copies always complementary
//
// Purpose: constants and carriers for the supply supervisor sequencer
// Assumes: 20 MHz core clock
// Notes:   times are in their printed units; cycle counts derive from them
package sssq_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned WARN_US         = 200;
    localparam int unsigned RESET_MS        = 100;
    localparam int unsigned WDOG_MS         = 400;
    localparam int unsigned SETUP_GAP_NS    = 100;
    localparam int unsigned WARN_CYC        = (CLK_HZ / 1_000_000) * WARN_US;
    localparam int unsigned RESET_CYC       = (CLK_HZ / 1_000) * RESET_MS;
    localparam int unsigned WDOG_CYC        = (CLK_HZ / 1_000) * WDOG_MS;
    localparam int unsigned SETUP_GAP_CYC   = (SETUP_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned TICK_DIV        = 20;
    localparam logic        MODE_NONBACKED  = 1'b0;

    typedef enum logic [4:0] {
        SSSQ_OFF   = 5'b00001,
        SSSQ_RUN   = 5'b00010,
        SSSQ_LOW   = 5'b00100,
        SSSQ_SLEEP = 5'b01000,
        SSSQ_SLOFF = 5'b10000
    } sssq_state_e;

    typedef struct packed {
        logic sense_low;
        logic supply_low;
        logic below_cell;
    } sssq_cmp_s;

    typedef struct packed {
        logic warn_n;
        logic warn_oe;
        logic reset_n;
        logic reset_hi;
        logic mem_select_out;
        logic power_fail;
        logic power_fail_n;
        logic cmp_enable;
    } sssq_out_s;
endpackage : sssq_pkg

// [hw/sssq_timer.sv]
// Purpose: loadable down counter with done pulse, counts on enable
// Assumes: synchronous active-low reset
// Notes:   load wins over counting
`timescale 1ns/1ps
`default_nettype none
module sssq_timer #(
    parameter int unsigned WIDTH = 24
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    input  wire logic             cnt_en,
    output logic                  running,
    output logic                  done
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             done;
    } sssq_tmr_s;
    sssq_tmr_s st_reg, st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (load) begin
            st_next.cnt = load_val;
        end else if (cnt_en && st_reg.cnt != '0) begin
            st_next.cnt = st_reg.cnt - WIDTH'(1);
            if (st_reg.cnt == WIDTH'(1)) begin
                st_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign running = st_reg.cnt != '0;
    assign done    = st_reg.done;
endmodule : sssq_timer
`default_nettype wire

// [hw/sssq_top.sv]
// Purpose: power-down, power-up, watchdog and sleep sequencing of a supply supervisor
// Assumes: comparator events already synchronous to core_clk; strobe pulses last a clock
// Notes:   long intervals count 1 us ticks so simulation may shorten the parameters
`timescale 1ns/1ps
`default_nettype none
module sssq_top
    import sssq_pkg::*;
#(
    parameter int unsigned WARN_TICKS  = WARN_US,
    parameter int unsigned RESET_TICKS = RESET_MS * 1000,
    parameter int unsigned WDOG_TICKS  = WDOG_MS * 1000,
    parameter int unsigned TICK_CYC    = TICK_DIV
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic mode_select,
    input  wire logic sense_low,
    input  wire logic supply_low,
    input  wire logic below_cell,
    input  wire logic mem_select_from_decoder,
    input  wire logic kick_pulse_n,
    input  wire logic wake_sleep_ctl,
    input  wire logic button_wake_n,
    output logic      warn_n,
    output logic      warn_oe,
    output logic      reset_n,
    output logic      reset_hi,
    output logic      mem_select_out,
    output logic      power_fail,
    output logic      power_fail_n,
    output logic      cmp_enable
);
    localparam int unsigned TW = 24;

    if (WARN_TICKS == 0 || RESET_TICKS == 0 || WDOG_TICKS == 0 || TICK_CYC < 2
        || RESET_TICKS >= (1 << TW) || WDOG_TICKS >= (1 << TW) || WARN_TICKS >= (1 << TW)
        || TICK_CYC >= 256 || SETUP_GAP_CYC >= 256) begin : g_bad_timing
        $error("sssq_top: timing parameter out of range");
    end

    typedef struct packed {
        sssq_state_e state;
        logic [7:0]  div;
        logic        tick;
        logic        kick_d;
        logic        btn_d;
        logic        wsc_d;
        logic        sense_d;
        logic [7:0]  gap;
        logic        armed;
        logic        rst_act;
        logic        warn_act;
        logic        warn_done;
        sssq_out_s   out;
    } sssq_st_s;

    sssq_st_s  st_reg, st_next;
    sssq_cmp_s cmp;
    logic      backed;
    logic      kick_fall, btn_fall, wsc_fall, sense_fall, sense_rise;
    logic      rst_load, warn_load, wd_load;
    logic      rst_run, warn_run, wd_run;
    logic      rst_done, warn_done_p, wd_done;

    // only the sense result is masked while asleep so a stale level cannot act; supply and cell results stay live
    always_comb begin
        cmp.sense_low  = sense_low  & st_reg.out.cmp_enable; // R14
        cmp.supply_low = supply_low;
        cmp.below_cell = below_cell;
    end

    assign backed     = (mode_select != MODE_NONBACKED); // R23
    assign kick_fall  = st_reg.kick_d & ~kick_pulse_n;
    assign btn_fall   = st_reg.btn_d & ~button_wake_n;
    assign wsc_fall   = st_reg.wsc_d & ~wake_sleep_ctl;
    assign sense_fall = ~st_reg.sense_d & cmp.sense_low;
    assign sense_rise = st_reg.sense_d & ~cmp.sense_low;

    sssq_timer #(.WIDTH(TW)) u_rst_tmr ( // R25
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .load     (rst_load),
        .load_val (TW'(RESET_TICKS)),
        .cnt_en   (st_reg.tick),
        .running  (rst_run),
        .done     (rst_done)
    );

    sssq_timer #(.WIDTH(TW)) u_warn_tmr (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .load     (warn_load),
        .load_val (TW'(WARN_TICKS)),
        .cnt_en   (st_reg.tick),
        .running  (warn_run),
        .done     (warn_done_p)
    );

    sssq_timer #(.WIDTH(TW)) u_wd_tmr (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .load     (wd_load),
        .load_val (TW'(WDOG_TICKS)),
        .cnt_en   (st_reg.tick),
        .running  (wd_run),
        .done     (wd_done)
    );

    always_comb begin
        st_next      = st_reg;
        rst_load     = 1'b0;
        warn_load    = 1'b0;
        wd_load      = 1'b0;
        st_next.tick = 1'b0;
        if (st_reg.div == 8'(TICK_CYC - 1)) begin
            st_next.div  = 8'h00;
            st_next.tick = 1'b1;
        end else begin
            st_next.div = st_reg.div + 8'h01;
        end
        st_next.kick_d  = kick_pulse_n;
        st_next.btn_d   = button_wake_n;
        st_next.wsc_d   = wake_sleep_ctl;
        st_next.sense_d = cmp.sense_low;

        // sleep gap: strobe fall arms, control must fall after the gap
        if (kick_fall) begin
            st_next.gap   = 8'h00;
            st_next.armed = 1'b1;
        end else if (st_reg.gap != 8'hFF) begin
            st_next.gap = st_reg.gap + 8'h01;
        end

        // a pulse begun before the supply dropped must still end on time
        if (warn_done_p && st_reg.state != SSSQ_RUN) begin
            st_next.warn_act  = 1'b0; // R24
            st_next.warn_done = 1'b1;
        end

        unique case (st_reg.state)
            SSSQ_OFF: begin
                st_next.rst_act = !backed; // R19 R20
                if (!cmp.below_cell) begin
                    st_next.state   = SSSQ_LOW;
                    st_next.rst_act = 1'b0;
                    if (!backed) begin
                        st_next.rst_act  = 1'b1; // R7 R11
                        rst_load         = 1'b1;
                    end else begin
                        st_next.rst_act = 1'b1; // R22
                        rst_load        = 1'b1;
                    end
                end
            end
            SSSQ_LOW: begin
                if (cmp.below_cell) begin
                    st_next.state = SSSQ_OFF;
                end else if (!cmp.supply_low) begin
                    st_next.state     = SSSQ_RUN;
                    st_next.warn_done = 1'b0;
                    wd_load           = 1'b1;
                    if (!backed) begin
                        st_next.warn_act = 1'b1; // R7
                        warn_load        = 1'b1;
                    end
                end
            end
            SSSQ_RUN: begin
                if (cmp.supply_low) begin
                    st_next.state = SSSQ_LOW;
                    if (!backed) begin
                        st_next.rst_act = 1'b1; // R5
                        rst_load        = 1'b1;
                    end
                end else if (wsc_fall && st_reg.armed
                             && st_reg.gap >= 8'(SETUP_GAP_CYC)) begin // R13
                    st_next.state    = SSSQ_SLEEP;
                    st_next.warn_act = 1'b0;
                    st_next.rst_act  = 1'b0;
                    st_next.armed    = 1'b0;
                end else begin
                    if (sense_fall) begin
                        st_next.warn_act  = 1'b1; // R1 R9
                        st_next.warn_done = 1'b0;
                        warn_load         = 1'b1;
                        if (backed && st_reg.rst_act) begin
                            st_next.rst_act = 1'b0;
                        end
                    end else if (warn_done_p) begin
                        st_next.warn_act  = 1'b0; // R24
                        st_next.warn_done = 1'b1;
                    end else if (backed && st_reg.warn_done && cmp.sense_low
                                 && kick_fall) begin
                        st_next.warn_act  = 1'b1;
                        st_next.warn_done = 1'b0;
                        warn_load         = 1'b1;
                    end
                    if (backed && sense_rise) begin
                        st_next.rst_act = 1'b1; // R12
                        rst_load        = 1'b1;
                    end
                    if (kick_fall) begin
                        wd_load = 1'b1; // R10
                    end else if (wd_done) begin
                        st_next.rst_act = 1'b1; // R10
                        rst_load        = 1'b1;
                        wd_load         = 1'b1;
                    end
                    if (rst_done && !(backed && sense_rise)) begin
                        st_next.rst_act = 1'b0; // R8
                        wd_load         = 1'b1;
                    end
                end
            end
            SSSQ_SLEEP: begin
                // strobe and sense are not looked at here
                if (cmp.below_cell) begin
                    st_next.state = SSSQ_SLOFF;
                    if (!backed) begin
                        st_next.rst_act = 1'b1; // R19
                    end
                end else if (cmp.supply_low && !backed) begin
                    st_next.rst_act = 1'b1; // R19
                end else if (btn_fall && !cmp.supply_low) begin // R16 R21
                    st_next.state     = SSSQ_RUN;
                    st_next.warn_done = 1'b1;
                    wd_load           = 1'b1; // R17
                end
            end
            SSSQ_SLOFF: begin
                if (!cmp.below_cell) begin // R18
                    st_next.state   = SSSQ_LOW;
                    st_next.rst_act = 1'b1; // R22
                    rst_load        = 1'b1;
                end
            end
            default: begin
                st_next.state = SSSQ_OFF;
            end
        endcase

        // a reset still being timed keeps running on its counter
        if (st_reg.state == SSSQ_RUN && !st_next.rst_act && rst_run && !rst_done
            && !(backed && st_reg.warn_act == 1'b0 && sense_fall)) begin
            st_next.rst_act = 1'b1; // R8
        end
        if (backed && st_reg.state == SSSQ_RUN && cmp.supply_low) begin
            st_next.rst_act = st_reg.rst_act & rst_run; // R2
        end
        if (st_next.state == SSSQ_SLEEP && backed) begin
            st_next.rst_act = 1'b0; // R20
        end

        st_next.out.cmp_enable     = (st_next.state != SSSQ_SLEEP); // R14 R15
        st_next.out.warn_n         = ~st_next.warn_act;
        st_next.out.warn_oe        = !(!backed && cmp.below_cell); // R6
        st_next.out.reset_hi       = st_next.rst_act;
        st_next.out.reset_n        = ~st_next.rst_act; // R26
        st_next.out.mem_select_out = mem_select_from_decoder | cmp.supply_low; // R3
        st_next.out.power_fail     = cmp.below_cell; // R4
        st_next.out.power_fail_n   = ~cmp.below_cell; // R26
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_reg                    <= '0;
            st_reg.state              <= SSSQ_OFF;
            st_reg.kick_d             <= 1'b1;
            st_reg.btn_d              <= 1'b1;
            st_reg.wsc_d              <= 1'b1;
            st_reg.gap                <= 8'hFF;
            st_reg.out.warn_n         <= 1'b1;
            st_reg.out.reset_n        <= 1'b0;
            st_reg.out.reset_hi       <= 1'b1;
            st_reg.out.mem_select_out <= 1'b1;
            st_reg.out.power_fail     <= 1'b1;
            st_reg.out.power_fail_n   <= 1'b0;
            st_reg.out.cmp_enable     <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign warn_n         = st_reg.out.warn_n;
    assign warn_oe        = st_reg.out.warn_oe;
    assign reset_n        = st_reg.out.reset_n;
    assign reset_hi       = st_reg.out.reset_hi;
    assign mem_select_out = st_reg.out.mem_select_out;
    assign power_fail     = st_reg.out.power_fail;
    assign power_fail_n   = st_reg.out.power_fail_n;
    assign cmp_enable     = st_reg.out.cmp_enable;
endmodule : sssq_top
`default_nettype wire

// [verification/sssq_chk.sv]
// Purpose: port checks for sssq_top
// Assumes: sim ticks 4/20/40/2, so a warning lasts at least 7 cycles
// Notes:   outputs lag their cause by one edge
`timescale 1ns/1ps
`default_nettype none
module sssq_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic mode_select,
    input wire logic sense_low,
    input wire logic supply_low,
    input wire logic below_cell,
    input wire logic mem_select_from_decoder,
    input wire logic kick_pulse_n,
    input wire logic wake_sleep_ctl,
    input wire logic button_wake_n,
    input wire logic warn_n,
    input wire logic warn_oe,
    input wire logic reset_n,
    input wire logic reset_hi,
    input wire logic mem_select_out,
    input wire logic power_fail,
    input wire logic power_fail_n,
    input wire logic cmp_enable
);
    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_warn_fall;
        $fell(warn_n) && !supply_low;
    endsequence
    sequence s_kick;
        $fell(kick_pulse_n);
    endsequence
    sequence s_sleep_req;
        $fell(wake_sleep_ctl) && reset_n && !supply_low;
    endsequence
    AST_RST_PAIR: assert property (reset_n != reset_hi)
        else $error("reset copies not complementary");
    AST_PF_PAIR: assert property (power_fail != power_fail_n)
        else $error("power fail copies not complementary");
    AST_PF_CELL: assert property ($past(rst_n) |-> power_fail == $past(below_cell))
        else $error("power fail does not follow cell level");
    AST_MEM_GATE: assert property ($past(rst_n) |->
        mem_select_out == ($past(supply_low) | $past(mem_select_from_decoder)))
        else $error("memory select not gated by low supply");
    AST_NB_RST: assert property (!mode_select && $rose(supply_low) |=> reset_hi)
        else $error("no reset on supply trip in non-backed mode");
    AST_BK_NORST: assert property (mode_select && $rose(supply_low) && reset_n |=> reset_n)
        else $error("reset on supply trip in backed mode");
    AST_FLOAT: assert property ($past(rst_n) |->
        warn_oe == !(!$past(mode_select) && $past(below_cell)))
        else $error("warning enable wrong");
    AST_WARN_LEN: assert property (s_warn_fall |-> !warn_n[*7])
        else $error("warning pulse too short");
    AST_SLEEP_IN: assert property (s_kick ##4 s_sleep_req |=> !cmp_enable)
        else $error("sleep not entered");
    AST_SLEEP_QUIET: assert property ($past(rst_n) && !cmp_enable && !$past(supply_low)
        |-> reset_n && warn_n)
        else $error("output active while asleep");
    AST_WAKE: assert property (!cmp_enable && $fell(button_wake_n) |=> cmp_enable)
        else $error("button did not wake");
endmodule : sssq_chk
bind sssq_top sssq_chk sssq_chk_inst (
    .core_clk(core_clk), .rst_n(rst_n), .mode_select(mode_select),
    .sense_low(sense_low), .supply_low(supply_low), .below_cell(below_cell),
    .mem_select_from_decoder(mem_select_from_decoder), .kick_pulse_n(kick_pulse_n),
    .wake_sleep_ctl(wake_sleep_ctl), .button_wake_n(button_wake_n), .warn_n(warn_n),
    .warn_oe(warn_oe), .reset_n(reset_n), .reset_hi(reset_hi),
    .mem_select_out(mem_select_out), .power_fail(power_fail),
    .power_fail_n(power_fail_n), .cmp_enable(cmp_enable)
);
`default_nettype wire

// [verification/sssq_cpu_model.sv]
// Purpose: processor stand-in that strobes and requests sleep
// Assumes: a strobe every 32 cycles sits well inside the watchdog period
// Notes:   a sleep request holds the control low until released
`timescale 1ns/1ps
`default_nettype none
module sssq_cpu_model (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic kick_en,
    input  wire logic sleep_req,
    output logic      kick_pulse_n,
    output logic      wake_sleep_ctl
);
    logic [4:0] tick_reg;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tick_reg       <= 5'h00;
            kick_pulse_n   <= 1'b1;
            wake_sleep_ctl <= 1'b1;
        end else begin
            tick_reg       <= tick_reg + 5'h01;
            kick_pulse_n   <= !(kick_en && tick_reg == 5'h00);
            // falls four cycles after the strobe, safely past the setup gap
            wake_sleep_ctl <= !(sleep_req && (tick_reg == 5'h04 || !wake_sleep_ctl));
        end
    end
endmodule : sssq_cpu_model
`default_nettype wire

// [verification/supply_supervisor_sequencer_tb.sv]
// Purpose: power, watchdog and sleep sequences in both modes
// Assumes: shortened ticks 4/20/40/2
// Notes:   notes are compared at the falling edge after they are queued
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_sequencer_tb
    import sssq_pkg::*;
;
    typedef struct {string nm; int idx; logic exp;} sssq_note_s;
    localparam int CMP = 0, PF = 2, MEM = 3, RH = 4, OE = 6, WN = 7;
    logic core_clk, rst_n = 1'b0, mode_select = 1'b0, sense_low = 1'b1;
    logic supply_low = 1'b1, below_cell = 1'b1, mem_dec = 1'b0, button_wake_n = 1'b1;
    logic kick_en = 1'b0, sleep_req = 1'b0, kick_pulse_n, wake_sleep_ctl, mb, d;
    wire sssq_out_s outs;
    sssq_note_s note_q[$];
    sssq_note_s n;
    string      fld [0:7] = '{"cmp", "pf_n", "pf", "mem", "rst_hi", "rst_n", "oe", "warn"};
    int         error_cnt = 0, check_count = 0, cycles = 0;
    integer     seed = 32'h1D3A;
    sssq_top #(.WARN_TICKS(4), .RESET_TICKS(20), .WDOG_TICKS(40), .TICK_CYC(2)) sssq_top_inst (
        .core_clk(core_clk), .rst_n(rst_n), .mode_select(mode_select),
        .sense_low(sense_low), .supply_low(supply_low), .below_cell(below_cell),
        .mem_select_from_decoder(mem_dec), .kick_pulse_n(kick_pulse_n),
        .wake_sleep_ctl(wake_sleep_ctl), .button_wake_n(button_wake_n),
        .warn_n(outs.warn_n), .warn_oe(outs.warn_oe), .reset_n(outs.reset_n),
        .reset_hi(outs.reset_hi), .mem_select_out(outs.mem_select_out),
        .power_fail(outs.power_fail), .power_fail_n(outs.power_fail_n),
        .cmp_enable(outs.cmp_enable));
    sssq_cpu_model sssq_cpu_model_inst (.core_clk(core_clk), .rst_n(rst_n), .kick_en(kick_en),
        .sleep_req(sleep_req), .kick_pulse_n(kick_pulse_n), .wake_sleep_ctl(wake_sleep_ctl));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic final_report;
        if (error_cnt == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    task automatic check(input string nm, input logic seen, input logic e);
        check_count++;
        if (seen !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", nm, e, seen);
        end
    endtask : check
    task automatic ex(input int idx, input logic e);
        note_q.push_back('{fld[idx], idx, e});
    endtask : ex
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask : cyc
    task automatic pwr(input logic sl, input logic sp, input logic bc);
        @(posedge core_clk);
        sense_low  <= sl;
        supply_low <= sp;
        below_cell <= bc;
        cyc(2);
    endtask : pwr
    // bounded wait; the queued note then fails if the level never came
    task automatic wait_bit(input int idx, input logic e, input int lim);
        for (int i = 0; i < lim && outs[idx] !== e; i++) @(posedge core_clk);
        cyc(1);
        ex(idx, e);
    endtask : wait_bit
    always @(negedge core_clk) begin
        while (note_q.size() > 0) begin
            n = note_q.pop_front();
            check(n.nm, outs[n.idx], n.exp);
        end
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 12000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        for (int m = 0; m < 2; m++) begin
            mb = m[0];
            @(posedge core_clk);
            rst_n       <= 1'b0;
            mode_select <= mb;
            kick_en     <= 1'b0;
            sense_low   <= 1'b1;
            supply_low  <= 1'b1;
            below_cell  <= 1'b1;
            cyc(8);
            rst_n   <= 1'b1;
            kick_en <= 1'b1;
            pwr(1, 1, 0);
            ex(PF, 0);
            ex(RH, 1);
            cyc(30);
            ex(RH, 1);
            pwr(1, 0, 0);
            wait_bit(RH, 0, 100);
            pwr(0, 0, 0);
            if (mb) ex(RH, 1);
            wait_bit(RH, 0, 100);
            cyc(200);
            ex(RH, 0);
            repeat (8) begin
                d = 1'($random(seed));
                mem_dec <= d;
                cyc(2);
                ex(MEM, d);
            end
            kick_en <= 1'b0;
            pwr(1, 0, 0);
            ex(WN, 0);
            cyc(12);
            ex(WN, 1);
            wait_bit(RH, 1, 150);
            kick_en <= 1'b1;
            pwr(0, 0, 0);
            wait_bit(RH, 0, 100);
            sleep_req <= 1'b1;
            wait_bit(CMP, 0, 60);
            pwr(1, 0, 0);
            cyc(20);
            ex(WN, 1);
            ex(RH, 0);
            button_wake_n <= 1'b0;
            sleep_req     <= 1'b0;
            kick_en       <= 1'b0;
            cyc(2);
            ex(CMP, 1);
            button_wake_n <= 1'b1;
            wait_bit(RH, 1, 150);
            kick_en <= 1'b1;
            pwr(0, 0, 0);
            wait_bit(RH, 0, 100);
            sleep_req <= 1'b1;
            wait_bit(CMP, 0, 60);
            pwr(1, 1, 0);
            ex(RH, ~mb);
            pwr(1, 1, 1);
            ex(PF, 1);
            ex(OE, mb);
            ex(RH, ~mb);
            sleep_req <= 1'b0;
            pwr(1, 1, 0);
            ex(CMP, 1);
            ex(RH, 1);
            pwr(0, 0, 0);
            wait_bit(RH, 0, 150);
            pwr(1, 0, 0);
            ex(WN, 0);
            cyc(10);
            pwr(1, 1, 0);
            ex(RH, ~mb);
            ex(MEM, 1);
            pwr(1, 1, 1);
            ex(PF, 1);
            ex(OE, mb);
        end
        cyc(2);
        final_report();
    end
endmodule : supply_supervisor_sequencer_tb
`default_nettype wire
